// file: design/ctcp_top.sv
// Capture timer with count source, filter clock, pin control and events.
// Assumes a strobe register port on clk_sys and pins from outside.
module ctcp_top
    import ctcp_pkg::*;
(
    input wire logic clk_sys,             // System clock, 200 MHz
    input wire logic reset,               // Async reset, active high
    input wire logic [7:0] reg_addr,      // Register byte address
    input wire logic [31:0] reg_wdata,    // Write data
    input wire logic reg_wr,              // Write strobe
    input wire logic reg_rd,              // Read strobe
    output logic [31:0] reg_rdata,        // Read data, cycle after strobe
    input wire logic capcmp_pin_a_in,     // Pin A level
    output logic capcmp_pin_a_out,        // Pin A drive value
    output logic capcmp_pin_a_oe,         // Pin A drive enable
    input wire logic capcmp_pin_b_in,     // Pin B level
    output logic capcmp_pin_b_out,        // Pin B drive value
    output logic capcmp_pin_b_oe,         // Pin B drive enable
    input wire logic ext_clock_a,         // External clock A
    input wire logic ext_clock_b,         // External clock B
    input wire logic event_link_pulse,    // Event link capture pulse
    output logic timer_irq                // Interrupt, level
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic timer_clock_supply_en_ff;
    logic count_run_ff;
    logic pwm_mode_sel_ff;
    logic filter_en_a_ff;
    logic filter_en_b_ff;
    logic [1:0] filter_clock_sel_ff;
    logic event_capture_en_ff;
    logic [2:0] count_source_sel_ff;
    logic [1:0] clr_sel_ff;
    logic [1:0] edge_a_ff;
    logic chan_a_mode_bit_ff;
    logic [1:0] edge_b_ff;
    logic chan_b_mode_bit_ff;
    logic [15:0] timer_counter_ff;
    logic [15:0] general_reg_a_ff;
    logic [15:0] general_reg_b_ff;
    logic [2:0] status_ff;
    logic [2:0] mask_ff;
    logic [1:0] port_latch_ff;
    logic [1:0] pin_oe_ff;
    logic [4:0] pres_ff;
    logic [1:0] ext_prev_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;

    // ----------------------------------------------------------------
    // Pin synchronisers and filters
    // ----------------------------------------------------------------
    logic [3:0] pin_sync;
    logic edge_a;
    logic edge_b;

    ctcp_sync #(.WIDTH(4)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .d_in({ext_clock_b, ext_clock_a, capcmp_pin_b_in, capcmp_pin_a_in}),
        .q_out(pin_sync)
    );

    // ----------------------------------------------------------------
    // Prescaler and count source
    // ----------------------------------------------------------------
    wire tick_div2 = pres_ff[0];
    wire tick_div4 = &pres_ff[1:0];
    wire tick_div8 = &pres_ff[2:0];
    wire tick_div32 = &pres_ff;
    wire ext_a_rise = pin_sync[2] & ~ext_prev_ff[0];
    wire ext_b_rise = pin_sync[3] & ~ext_prev_ff[1];
    wire src_tick = (count_source_sel_ff == SRC_CLK) ? 1'b1 :
                    (count_source_sel_ff == SRC_DIV2) ? tick_div2 :
                    (count_source_sel_ff == SRC_DIV4) ? tick_div4 :
                    (count_source_sel_ff == SRC_DIV8) ? tick_div8 :
                    (count_source_sel_ff == SRC_DIV32) ? tick_div32 :
                    (count_source_sel_ff == SRC_EXT_A) ? ext_a_rise :
                    (count_source_sel_ff == SRC_EXT_B) ? ext_b_rise : 1'b0;
    wire filt_tick = (filter_clock_sel_ff == FCK_DIV32) ? tick_div32 :
                     (filter_clock_sel_ff == FCK_DIV8) ? tick_div8 :
                     (filter_clock_sel_ff == FCK_CLK) ? 1'b1 : src_tick;

    ctcp_pin_filter u_filt_a (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(pin_sync[0]),
        .is_input(~pin_oe_ff[0]),
        .filt_en(filter_en_a_ff),
        .samp_tick(filt_tick),
        .edge_sel(edge_a_ff),
        .edge_pulse(edge_a)
    );

    ctcp_pin_filter u_filt_b (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(pin_sync[1]),
        .is_input(~pin_oe_ff[1]),
        .filt_en(filter_en_b_ff),
        .samp_tick(filt_tick),
        .edge_sel(edge_b_ff),
        .edge_pulse(edge_b)
    );

    // ----------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------
    wire always_open = (reg_addr == OFS_PERIPH) || (reg_addr == OFS_LATCH) ||
                       (reg_addr == OFS_DIR);
    wire reg_open = timer_clock_supply_en_ff | always_open;
    wire wr_ok = reg_wr & reg_open;
    wire wr_periph = wr_ok & (reg_addr == OFS_PERIPH);
    wire wr_mode = wr_ok & (reg_addr == OFS_MODE);
    wire wr_ctrl = wr_ok & (reg_addr == OFS_CTRL);
    wire wr_capcmp = wr_ok & (reg_addr == OFS_CAPCMP);
    wire wr_cnt = wr_ok & (reg_addr == OFS_CNT);
    wire wr_gra = wr_ok & (reg_addr == OFS_GRA);
    wire wr_grb = wr_ok & (reg_addr == OFS_GRB);
    wire wr_status = wr_ok & (reg_addr == OFS_STATUS);
    wire wr_mask = wr_ok & (reg_addr == OFS_MASK);
    wire wr_latch = wr_ok & (reg_addr == OFS_LATCH);
    wire wr_dir = wr_ok & (reg_addr == OFS_DIR);

    // ----------------------------------------------------------------
    // Capture, clear and count
    // ----------------------------------------------------------------
    wire active = timer_clock_supply_en_ff;
    wire evt_ok = event_capture_en_ff & chan_b_mode_bit_ff &
                  (edge_b_ff == EDGE_RISE) & ~pwm_mode_sel_ff;
    wire cap_a = active & chan_a_mode_bit_ff & edge_a;
    wire cap_b = active & chan_b_mode_bit_ff &
                 (edge_b | (event_link_pulse & evt_ok));
    wire hw_clr = (cap_a & (clr_sel_ff == CLR_ON_A)) |
                  (cap_b & (clr_sel_ff == CLR_ON_B));
    wire cnt_tick = active & count_run_ff & src_tick;
    wire cnt_ovf = cnt_tick & (&timer_counter_ff) & ~wr_cnt & ~hw_clr;
    wire [15:0] nxt_timer_counter = wr_cnt ? reg_wdata[15:0] :
                                    hw_clr ? 16'h0000 :
                                    cnt_tick ? timer_counter_ff + 16'h0001 :
                                    timer_counter_ff;
    wire [2:0] st_set = {cnt_ovf, cap_b, cap_a};
    wire [2:0] st_clr = wr_status ? reg_wdata[2:0] : 3'h0;
    wire [2:0] nxt_status = (status_ff & ~st_clr) | st_set;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [31:0] mode_word = {25'h0, event_capture_en_ff, filter_clock_sel_ff,
                             filter_en_b_ff, filter_en_a_ff, pwm_mode_sel_ff,
                             count_run_ff};
    wire [31:0] capcmp_word = {25'h0, chan_b_mode_bit_ff, edge_b_ff, 1'b0,
                               chan_a_mode_bit_ff, edge_a_ff};
    wire [31:0] rd_val = (reg_addr == OFS_PERIPH) ? {31'h0, timer_clock_supply_en_ff} :
                         (reg_addr == OFS_MODE) ? mode_word :
                         (reg_addr == OFS_CTRL) ? {27'h0, clr_sel_ff, count_source_sel_ff} :
                         (reg_addr == OFS_CAPCMP) ? capcmp_word :
                         (reg_addr == OFS_CNT) ? {16'h0, timer_counter_ff} :
                         (reg_addr == OFS_GRA) ? {16'h0, general_reg_a_ff} :
                         (reg_addr == OFS_GRB) ? {16'h0, general_reg_b_ff} :
                         (reg_addr == OFS_STATUS) ? {29'h0, status_ff} :
                         (reg_addr == OFS_MASK) ? {29'h0, mask_ff} :
                         (reg_addr == OFS_LATCH) ? {30'h0, port_latch_ff} :
                         (reg_addr == OFS_DIR) ? {30'h0, ~pin_oe_ff} : READ_DEFAULT;
    wire [31:0] nxt_rdata = (reg_rd & reg_open) ? rd_val : READ_DEFAULT;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            timer_clock_supply_en_ff <= 1'b0;
            count_run_ff <= 1'b0;
            pwm_mode_sel_ff <= 1'b0;
            filter_en_a_ff <= 1'b0;
            filter_en_b_ff <= 1'b0;
            filter_clock_sel_ff <= FCK_RST;
            event_capture_en_ff <= 1'b0;
            count_source_sel_ff <= SRC_CLK;
            clr_sel_ff <= 2'h0;
            edge_a_ff <= EDGE_RISE;
            chan_a_mode_bit_ff <= 1'b0;
            edge_b_ff <= EDGE_RISE;
            chan_b_mode_bit_ff <= 1'b0;
        end else begin
            if (wr_periph) begin
                timer_clock_supply_en_ff <= reg_wdata[0];
            end
            if (wr_mode) begin
                count_run_ff <= reg_wdata[MODE_RUN];
                pwm_mode_sel_ff <= reg_wdata[MODE_PWM];
                filter_en_a_ff <= reg_wdata[MODE_FEN_A];
                filter_en_b_ff <= reg_wdata[MODE_FEN_B];
                filter_clock_sel_ff <= reg_wdata[MODE_FCK +: 2];
                event_capture_en_ff <= reg_wdata[MODE_EVC];
            end
            if (wr_ctrl) begin
                count_source_sel_ff <= reg_wdata[CTRL_SRC +: 3];
                clr_sel_ff <= reg_wdata[CTRL_CLR +: 2];
            end
            if (wr_capcmp) begin
                edge_a_ff <= reg_wdata[IO_EDGE_A +: 2];
                chan_a_mode_bit_ff <= reg_wdata[IO_MODE_A];
                edge_b_ff <= reg_wdata[IO_EDGE_B +: 2];
                chan_b_mode_bit_ff <= reg_wdata[IO_MODE_B];
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter, captures, status and pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            timer_counter_ff <= 16'h0000;
            general_reg_a_ff <= 16'h0000;
            general_reg_b_ff <= 16'h0000;
            status_ff <= 3'h0;
            mask_ff <= 3'h0;
            port_latch_ff <= LATCH_RST;
            pin_oe_ff <= ~DIR_RST;
            pres_ff <= 5'h00;
            ext_prev_ff <= 2'h0;
            rdata_ff <= READ_DEFAULT;
            irq_ff <= 1'b0;
        end else begin
            timer_counter_ff <= nxt_timer_counter;
            general_reg_a_ff <= wr_gra ? reg_wdata[15:0] :
                                cap_a ? timer_counter_ff : general_reg_a_ff;
            general_reg_b_ff <= wr_grb ? reg_wdata[15:0] :
                                cap_b ? timer_counter_ff : general_reg_b_ff;
            status_ff <= nxt_status;
            if (wr_mask) begin
                mask_ff <= reg_wdata[2:0];
            end
            if (wr_latch) begin
                port_latch_ff <= reg_wdata[1:0];
            end
            if (wr_dir) begin
                pin_oe_ff <= ~reg_wdata[1:0];
            end
            pres_ff <= pres_ff + 5'h01;
            ext_prev_ff <= pin_sync[3:2];
            rdata_ff <= nxt_rdata;
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    assign reg_rdata = rdata_ff;
    assign capcmp_pin_a_out = port_latch_ff[0];
    assign capcmp_pin_b_out = port_latch_ff[1];
    assign capcmp_pin_a_oe = pin_oe_ff[0];
    assign capcmp_pin_b_oe = pin_oe_ff[1];
    assign timer_irq = irq_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_bad_src_halt: assert property (@(posedge clk_sys) disable iff (reset)
        (count_source_sel_ff == 3'h6) |-> !cnt_tick)
        else $error("reserved count source ticked");
    a_div8_tick: assert property (@(posedge clk_sys) disable iff (reset)
        (cnt_tick && count_source_sel_ff == SRC_DIV8) |-> (pres_ff[2:0] == 3'h7))
        else $error("divide by 8 tick misplaced");
    a_filt_div32: assert property (@(posedge clk_sys) disable iff (reset)
        (filter_clock_sel_ff == FCK_DIV32 && filt_tick) |-> (pres_ff == 5'h1F))
        else $error("filter div 32 tick misplaced");
    a_drive_needs_dir: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(pin_oe_ff[0]) |-> $past(wr_dir && !reg_wdata[0]))
        else $error("pin A driven without direction write");
    a_gated_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && !timer_clock_supply_en_ff && reg_addr == OFS_MODE) |=> $stable(mode_word))
        else $error("mode written while supply off");
    a_gated_read: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_rd && !timer_clock_supply_en_ff && reg_addr == OFS_CNT) |=> (reg_rdata == 32'h0))
        else $error("counter read while supply off");
    a_event_capture: assert property (@(posedge clk_sys) disable iff (reset)
        (event_link_pulse && evt_ok && active && !wr_grb)
        |=> (general_reg_b_ff == $past(timer_counter_ff)))
        else $error("event pulse missed capture B");
    a_event_blocked: assert property (@(posedge clk_sys) disable iff (reset)
        (event_link_pulse && (pwm_mode_sel_ff || !chan_b_mode_bit_ff) && !edge_b && !wr_grb)
        |=> $stable(general_reg_b_ff))
        else $error("event captured in blocked mode");
    a_write_beats_clr: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cnt && hw_clr) |=> (timer_counter_ff == $past(reg_wdata[15:0])))
        else $error("hardware clear beat software write");
    a_pin_capture: assert property (@(posedge clk_sys) disable iff (reset)
        (cap_a && !wr_gra) |=> (general_reg_a_ff == $past(timer_counter_ff)))
        else $error("capture A value wrong");
    a_stop_holds: assert property (@(posedge clk_sys) disable iff (reset)
        (!count_run_ff && !wr_cnt && !hw_clr) |=> $stable(timer_counter_ff))
        else $error("counter moved while stopped");
    a_wrap_zero: assert property (@(posedge clk_sys) disable iff (reset)
        cnt_ovf |=> (timer_counter_ff == 16'h0000 && status_ff[ST_OVF]))
        else $error("overflow did not wrap");
endmodule

// file: design/ctcp_pkg.sv
// Constants for the capture timer configuration and pin control block.
// Assumes a single 200 MHz clock and a plain strobe register port.
// Function
// - Count source field picks the counter tick
// - Filter clock field picks the filter sampling clock
// - Capture pins are inputs after reset
// - Edge guard after output-to-input switch
// - Supply disabled: writes ignored, reads give defaults, except the peripheral, latch and direction registers
// - Event pulse triggers capture B when enabled
// - Event capture blocked in PWM or compare mode
// - Software counter write beats hardware clear
// - Selected pin edge copies counter to general register
// - Run bit starts and stops counting
package ctcp_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PERIPH = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_CAPCMP = 8'h0C;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_GRA = 8'h14;
    localparam logic [7:0] OFS_GRB = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_LATCH = 8'h24;
    localparam logic [7:0] OFS_DIR = 8'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MODE_RUN = 0;
    localparam int MODE_PWM = 1;
    localparam int MODE_FEN_A = 2;
    localparam int MODE_FEN_B = 3;
    localparam int MODE_FCK = 4;
    localparam int MODE_EVC = 6;
    localparam int CTRL_SRC = 0;
    localparam int CTRL_CLR = 3;
    localparam int IO_EDGE_A = 0;
    localparam int IO_MODE_A = 2;
    localparam int IO_EDGE_B = 4;
    localparam int IO_MODE_B = 6;
    localparam int ST_CAP_A = 0;
    localparam int ST_CAP_B = 1;
    localparam int ST_OVF = 2;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_CLK = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_DIV32 = 3'h4;
    localparam logic [2:0] SRC_EXT_A = 3'h5;
    localparam logic [2:0] SRC_EXT_B = 3'h7;
    localparam logic [1:0] FCK_DIV32 = 2'h0;
    localparam logic [1:0] FCK_DIV8 = 2'h1;
    localparam logic [1:0] FCK_CLK = 2'h2;
    localparam logic [1:0] FCK_RST = FCK_DIV32;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] CLR_ON_A = 2'h1;
    localparam logic [1:0] CLR_ON_B = 2'h2;
    localparam logic [1:0] DIR_RST = 2'h3;
    localparam logic [1:0] LATCH_RST = 2'h0;
    localparam logic [31:0] READ_DEFAULT = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing: edge guard after a pin turns to input
    // ----------------------------------------------------------------
    localparam logic [2:0] GUARD_NOFILT = 3'h2;
    localparam logic [2:0] GUARD_FILT = 3'h5;

endpackage

// file: design/ctcp_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs may change at any time against clk_sys.
module ctcp_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,            // System clock
    input wire logic reset,              // Async reset, active high
    input wire logic [WIDTH-1:0] d_in,   // Asynchronous levels
    output logic [WIDTH-1:0] q_out       // Synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule

// file: design/ctcp_pin_filter.sv
// Per-pin digital filter, post-switch edge guard and edge selection.
// Assumes pin_in is already synchronised to clk_sys.
module ctcp_pin_filter
    import ctcp_pkg::*;
(
    input wire logic clk_sys,          // System clock
    input wire logic reset,            // Async reset, active high
    input wire logic pin_in,           // Synchronised pin level
    input wire logic is_input,         // Pin direction is input
    input wire logic filt_en,          // Digital filter enabled
    input wire logic samp_tick,        // Filter sampling tick
    input wire logic [1:0] edge_sel,   // Valid edge choice
    output logic edge_pulse            // One-cycle valid edge
);
    logic [2:0] smp_ff;
    logic lvl_ff;
    logic [2:0] guard_ff;
    logic edge_ff;

    wire agree_hi = &smp_ff;
    wire agree_lo = ~|smp_ff;
    wire filt_lvl = agree_hi ? 1'b1 : (agree_lo ? 1'b0 : lvl_ff);
    wire nxt_lvl = filt_en ? filt_lvl : pin_in;
    wire guard_step = filt_en ? samp_tick : 1'b1;
    wire guard_done = (guard_ff == 3'h0);
    wire rise = nxt_lvl & ~lvl_ff;
    wire fall = ~nxt_lvl & lvl_ff;
    wire sel_edge = (edge_sel == EDGE_RISE) ? rise :
                    (edge_sel == EDGE_FALL) ? fall : (rise | fall);
    wire [2:0] nxt_guard = !is_input ? (filt_en ? GUARD_FILT : GUARD_NOFILT) :
                           (!guard_done && guard_step) ? guard_ff - 3'h1 : guard_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            smp_ff <= 3'h0;
            lvl_ff <= 1'b0;
            guard_ff <= 3'h0;
            edge_ff <= 1'b0;
        end else begin
            if (samp_tick) begin
                smp_ff <= {smp_ff[1:0], pin_in};
            end
            lvl_ff <= nxt_lvl;
            guard_ff <= nxt_guard;
            edge_ff <= is_input & guard_done & sel_edge;
        end
    end

    assign edge_pulse = edge_ff;

    a_guard_blocks_edge: assert property (@(posedge clk_sys) disable iff (reset)
        (!guard_done || !is_input) |=> !edge_ff)
        else $error("edge seen during post-switch guard");
endmodule

// file: dv/ctcp_far_model.sv
// Far side: capture pin lines, external count clocks, event link.
// Assumes the bench commands levels and runs; all changes follow clk_sys.
module ctcp_far_model (
    input wire logic clk_sys,       // System clock
    input wire logic [1:0] pin_oe,  // Design drive enables, A in bit 0
    input wire logic [1:0] pin_out, // Design drive values
    input wire logic [1:0] lvl,     // Levels applied from outside
    input wire logic [1:0] ext_run, // Run external clock A, B
    input wire logic evt_req,       // Ask for one event pulse
    output logic [1:0] pin_in,      // Resolved pin levels
    output logic ext_clock_a,       // External clock A
    output logic ext_clock_b,       // External clock B
    output logic event_link_pulse   // One-cycle event
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_ff = 2'h0;
    // Wire level: the design wins while it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
    // Clocks stand low when not running
    always @(posedge clk_sys) begin
        div_ff <= div_ff + 2'h1;
        ext_clock_a <= ext_run[0] & div_ff[1];
        ext_clock_b <= ext_run[1] & div_ff[1];
        event_link_pulse <= evt_req & !event_link_pulse;
    end
endmodule

// file: dv/capture_timer_config_and_pin_control_test.sv
// Self-checking bench: register port, count sources, capture, events, pins.
// Assumes ctcp_pkg, ctcp_top and ctcp_far_model are compiled first.
module capture_timer_config_and_pin_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ctcp_pkg::*;
    logic clk_sys, reset, reg_wr, reg_rd, irq, evt_req;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, e, v;
    logic [1:0] oe, po, pin_in, lvl, ext_run;
    logic eca, ecb, evt;
    int err_total = 0, n_compared = 0, cyc = 0;
    int dv[8] = '{1, 2, 4, 8, 32, 4, 0, 4};
    logic [31:0] cc[4] = '{32'h40, 32'h40, 32'h00, 32'h50};
    logic [31:0] md[4] = '{32'h40, 32'h42, 32'h40, 32'h40};
    ctcp_top ctcp_top_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capcmp_pin_a_in(pin_in[0]), .capcmp_pin_a_out(po[0]), .capcmp_pin_a_oe(oe[0]),
        .capcmp_pin_b_in(pin_in[1]), .capcmp_pin_b_out(po[1]), .capcmp_pin_b_oe(oe[1]),
        .ext_clock_a(eca), .ext_clock_b(ecb), .event_link_pulse(evt), .timer_irq(irq));
    ctcp_far_model ctcp_far_model_inst (.clk_sys(clk_sys), .pin_oe(oe), .pin_out(po),
        .lvl(lvl), .ext_run(ext_run), .evt_req(evt_req), .pin_in(pin_in),
        .ext_clock_a(eca), .ext_clock_b(ecb), .event_link_pulse(evt));
    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
        n_compared++;
        if (g !== ex) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(string nm, logic [7:0] a, logic [31:0] ex);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk(nm, ex, d);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, lvl, ext_run, evt_req} = '0;
        reset = 1'b1;
        void'($urandom(32'he821a1fc));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rc("direction", OFS_DIR, 32'(DIR_RST));
        chk("pin_oe", 32'h0, 32'(oe));
        wr(OFS_CNT, 32'h1234);
        wr(OFS_MODE, 32'h7F);
        rc("count_gated", OFS_CNT, READ_DEFAULT);
        wr(OFS_LATCH, 32'h2);
        rc("latch_open", OFS_LATCH, 32'h2);
        wr(OFS_LATCH, 32'h0);
        wr(OFS_PERIPH, 32'h1);
        rc("mode_reset", OFS_MODE, 32'h0);
        rc("unmapped", 8'hFC, 32'h0);
        $display("test reset and supply done");
        for (int i = 0; i < 8; i++) begin
            v = 32'hFFC0 | ($urandom & 32'h1F);
            ext_run <= (i == 5) ? 2'h1 : (i == 6) ? 2'h3 : (i == 7) ? 2'h2 : 2'h0;
            wr(OFS_CTRL, 32'(i));
            wr(OFS_CNT, v);
            wr(OFS_MODE, 32'h1);
            repeat (62) @(posedge clk_sys);
            wr(OFS_MODE, 32'h0);
            e = (v + ((i == 6) ? 0 : 64 / dv[i])) & 32'hFFFF;
            rc("count", OFS_CNT, e);
        end
        ext_run <= 2'h0;
        $display("test count sources done");
        wr(OFS_STATUS, 32'h7);
        wr(OFS_MASK, 32'h1);
        for (int k = 0; k < 2; k++) begin
            v = $urandom & 32'hFFFF;
            wr(OFS_CNT, v);
            wr(OFS_MODE, k ? 32'h0 : 32'h24);
            wr(OFS_CAPCMP, 32'h4 | k);
            lvl[0] <= (k == 0);
            repeat (12) @(posedge clk_sys);
            chk("irq_set", 32'h1, 32'(irq));
            rc("general_a", OFS_GRA, v);
            wr(OFS_STATUS, 32'h1);
            repeat (3) @(posedge clk_sys);
            chk("irq_clear", 32'h0, 32'(irq));
        end
        // Capture A clears the counter in the very cycle software writes it
        wr(OFS_CTRL, 32'h8);
        wr(OFS_CAPCMP, 32'h6);
        lvl[0] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wr(OFS_CNT, 32'h1234);
        rc("write_beats_clear", OFS_CNT, 32'h1234);
        rc("general_a_both", OFS_GRA, v);
        $display("test pin capture done");
        for (int j = 0; j < 4; j++) begin
            v = $urandom & 32'hFFFF;
            wr(OFS_CAPCMP, cc[j]);
            wr(OFS_MODE, md[j]);
            wr(OFS_GRB, 32'h0);
            wr(OFS_CNT, v);
            evt_req <= 1'b1;
            @(posedge clk_sys);
            evt_req <= 1'b0;
            repeat (4) @(posedge clk_sys);
            rc("general_b", OFS_GRB, (j == 0) ? v : 32'h0);
            wr(OFS_STATUS, 32'h2);
        end
        $display("test event capture done");
        wr(OFS_MODE, 32'h0);
        wr(OFS_LATCH, 32'h0);
        wr(OFS_DIR, 32'h0);
        wr(OFS_MODE, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("pin_drive", 32'hC, {28'h0, oe, po});
        wr(OFS_DIR, 32'h3);
        wr(OFS_CAPCMP, 32'h4);
        wr(OFS_MODE, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("pin_release", 32'h0, 32'(oe));
        $display("test pin direction done");
        summarize();
    end
endmodule
